// [spi_flag_pkg.sv]
// Purpose: Shared constants and types for the serial port status flag logic.
// Assumes: Special-function registers are reached over an 8-bit SFR port.
// Notes:   Every offset, bit position and reset value is named here once.
//
// Contract
// - Busy bit 7 is high while transferring as master or slave, low when idle.
// - Multimaster error bit 6 sets on enabled select while master; zero write clears. Code sets it only during an active master frame, not while idle.
// - Mode 1: overflow bit 5 sets if receive buffer unread at byte end.
// - On overflow with overwrite enabled, the new byte replaces the buffer.
// - On overflow with overwrite disabled, the new byte is dropped.
// - Receive interrupt bit 4 sets on a new byte, requests interrupt, read clears.
// - Mode 0: unread receive buffer at byte end stops transfer, releases select.
// - Receive full bit 3 sets when buffer full; receive read clears it.
// - Transmit underflow bit 2 sets on underflow; writing zero clears it.
// - Transmit interrupt bit 1 sets on empty buffer; new byte write clears.
// - Mode 1: no new byte by byte end stops transfer; zero write clears.
// - Transmit full bit 0 set while unsent data held; zero write clears.

package spi_flag_pkg;

    // ************************************************************
    // Special-function register addresses.
    // ************************************************************
    localparam logic [7:0] STATUS_ADDR  = 8'hEA;
    localparam logic [7:0] TX_BUF_ADDR  = 8'h9A;
    localparam logic [7:0] RX_BUF_ADDR  = 8'h9B;

    // ************************************************************
    // Status register bit positions.
    // ************************************************************
    localparam int BUSY_BIT    = 7;
    localparam int MULTIMASTER_ERROR_FLAG_BIT   = 6;
    localparam int RX_OF_BIT   = 5;
    localparam int RX_IRQ_BIT  = 4;
    localparam int RX_FULL_BIT = 3;
    localparam int TX_UF_BIT   = 2;
    localparam int TX_IRQ_BIT  = 1;
    localparam int TX_FULL_BIT = 0;

    // ************************************************************
    // Reset values and link constants.
    // ************************************************************
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET   = 8'h00;
    localparam logic [7:0] IDLE_FILL    = 8'hFF;
    localparam logic [2:0] LAST_BIT     = 3'h7;
    localparam logic [2:0] FIRST_BIT    = 3'h0;

    // Transfer state of the core-side controller.
    typedef enum logic [0:0] {
        IDLE,
        ACTIVE
    } core_state_type;

    // Complete core-side state.
    typedef struct packed {
        core_state_type state;
        logic           ss_meta;
        logic           ss_sync;
        logic           done_meta;
        logic           done_sync;
        logic           done_seen;
        logic           busy;
        logic           multimaster_error_flag;
        logic           rx_of;
        logic           rx_irq;
        logic           rx_full;
        logic           tx_uf;
        logic           tx_irq;
        logic           tx_full;
        logic [7:0]     rx_buf;
        logic [7:0]     tx_buf;
        logic [7:0]     shift_data;
        logic [7:0]     rdata;
        logic           frame;
        logic           ss_n_drive;
        logic           ss_oe_n;
        logic           irq;
    } core_reg_type;

    // Complete link-side state.
    typedef struct packed {
        logic       frame_meta;
        logic       frame_sync;
        logic [2:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] rx_hold;
        logic       done_tgl;
        logic       sdo;
    } link_reg_type;

endpackage

// [spi_link_shifter.sv]
// Purpose: Link-domain byte shifter clocked by the serial clock.
// Assumes: One data bit is shifted out and one sampled on each rising link clock edge.
// Notes:   A finished byte is signalled by a toggle with a stable word.

`timescale 1ns/1ps
`default_nettype none

module spi_link_shifter
    import spi_flag_pkg::*;
(
    // Link clock and reset.
    input  wire logic       link_clk_in,
    input  wire logic       reset_n_in,
    // Core side.
    input  wire logic       frame_in,
    input  wire logic [7:0] tx_byte_in,
    output logic      [7:0] rx_byte_out,
    output logic            done_toggle_out,
    // Serial data.
    input  wire logic       serial_data_in,
    output logic            serial_data_out
);

    link_reg_type r;
    link_reg_type n;
    logic [7:0]   word;

    // Next state: the byte counter restarts whenever the frame is closed.
    always_comb begin
        n = r;
        word = (r.bit_cnt == FIRST_BIT) ? tx_byte_in : r.shreg;
        n.frame_meta = frame_in;
        n.frame_sync = r.frame_meta;
        if (!r.frame_sync) begin
            n.bit_cnt = FIRST_BIT;
            n.sdo = tx_byte_in[7];
        end else begin
            n.sdo = word[7];
            n.shreg = {word[6:0], serial_data_in};
            n.bit_cnt = r.bit_cnt + 3'h1;
            // The captured word stands for a full byte time after the toggle.
            if (r.bit_cnt == LAST_BIT) begin
                n.rx_hold = {word[6:0], serial_data_in};
                n.done_tgl = ~r.done_tgl;
            end
        end
    end

    // State register on the link clock.
    always_ff @(posedge link_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign rx_byte_out = r.rx_hold;
    assign done_toggle_out = r.done_tgl;
    assign serial_data_out = r.sdo;

endmodule

`default_nettype wire

// [spi_status_flag_logic.sv]
// Purpose: Status flags, buffers and transfer control of the serial port.
// Assumes: Core clock at 200 MHz; the link clock is unrelated in phase.
// Notes:   Read data answers one cycle after the address is presented.

`timescale 1ns/1ps
`default_nettype none

module spi_status_flag_logic
    import spi_flag_pkg::*;
(
    // Core clock and reset.
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    // Special-function register port.
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    input  wire logic [7:0] sfr_wdata_in,
    output logic      [7:0] sfr_rdata_out,
    // Configuration levels.
    input  wire logic       master_mode_in,
    input  wire logic       ss_input_enable_in,
    input  wire logic       transfer_interrupt_mode_select_in,
    input  wire logic       receive_overwrite_enable_in,
    input  wire logic       serial_irq_enable_in,
    // Interrupt request.
    output logic            serial_irq_out,
    // Slave select pin.
    input  wire logic       ss_n_in,
    output logic            ss_n_out,
    output logic            ss_oe_n_out,
    // Link.
    input  wire logic       link_clk_in,
    input  wire logic       serial_data_in,
    output logic            serial_data_out
);

    // ************************************************************
    // State and link instance.
    // ************************************************************
    core_reg_type r;
    core_reg_type n;
    logic [7:0]   link_rx_byte;
    logic         link_done_tgl;

    spi_link_shifter link_shifter (
        .link_clk_in     (link_clk_in),
        .reset_n_in      (reset_n_in),
        .frame_in        (r.frame),
        .tx_byte_in      (r.shift_data),
        .rx_byte_out     (link_rx_byte),
        .done_toggle_out (link_done_tgl),
        .serial_data_in  (serial_data_in),
        .serial_data_out (serial_data_out)
    );

    // ************************************************************
    // Decode helpers.
    // ************************************************************

    // True when an access targets the given address.
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = (addr == target);
    endfunction

    // Assembled status byte.
    function automatic logic [7:0] status_of(input core_reg_type s);
        status_of = {s.busy, s.multimaster_error_flag, s.rx_of, s.rx_irq,
                     s.rx_full, s.tx_uf, s.tx_irq, s.tx_full};
    endfunction

    logic       wr_status;
    logic       wr_tx;
    logic       rd_rx;
    logic       byte_done;
    logic       slave_sel;
    logic       tx_avail;
    logic [7:0] tx_next;
    logic       stop;

    // Access strobes; a status read decodes to nothing on purpose.
    always_comb begin
        wr_status = sfr_wr_in && hit(sfr_addr_in, STATUS_ADDR);
        wr_tx     = sfr_wr_in && hit(sfr_addr_in, TX_BUF_ADDR);
        rd_rx     = sfr_rd_in && hit(sfr_addr_in, RX_BUF_ADDR);
        byte_done = r.done_sync ^ r.done_seen;
        slave_sel = ~r.ss_sync;
        tx_avail  = r.tx_full | wr_tx;
        tx_next   = wr_tx ? sfr_wdata_in : r.tx_buf;
    end

    // ************************************************************
    // Next-state logic.
    // ************************************************************

    // Clears are applied first so that a same-cycle hardware set wins.
    always_comb begin
        n = r;
        stop = 1'b0;
        n.ss_meta   = ss_n_in;
        n.ss_sync   = r.ss_meta;
        n.done_meta = link_done_tgl;
        n.done_sync = r.done_meta;
        n.done_seen = r.done_sync;

        // Software clears.
        if (wr_status) begin
            if (!sfr_wdata_in[MULTIMASTER_ERROR_FLAG_BIT]) begin
                n.multimaster_error_flag = 1'b0;
            end
            if (!sfr_wdata_in[TX_UF_BIT]) begin
                n.tx_uf = 1'b0;
            end
            if (!sfr_wdata_in[TX_IRQ_BIT]) begin
                n.tx_irq = 1'b0;
            end
            if (!sfr_wdata_in[TX_FULL_BIT]) begin
                n.tx_full = 1'b0;
            end
        end
        if (rd_rx) begin
            n.rx_of   = 1'b0;
            n.rx_irq  = 1'b0;
            n.rx_full = 1'b0;
        end
        if (wr_tx) begin
            n.tx_buf  = sfr_wdata_in;
            n.tx_full = 1'b1;
            n.tx_irq  = 1'b0;
        end

        // Another master selecting us while we drive the bus.
        if (ss_input_enable_in && master_mode_in && r.state == ACTIVE
            && slave_sel) begin
            n.multimaster_error_flag = 1'b1;
        end

        unique case (r.state)
            IDLE: begin
                // A master starts on a queued byte; a slave on select.
                if ((master_mode_in && tx_avail)
                    || (!master_mode_in && slave_sel)) begin
                    n.state = ACTIVE;
                    n.frame = 1'b1;
                    n.ss_n_drive = ~master_mode_in;
                    if (tx_avail) begin
                        n.shift_data = tx_next;
                        n.tx_full = 1'b0;
                        n.tx_irq  = 1'b1;
                    end else begin
                        n.shift_data = IDLE_FILL;
                    end
                end
            end
            ACTIVE: begin
                if (byte_done) begin
                    // Receive side of the finished byte.
                    if (r.rx_irq && !rd_rx) begin
                        if (transfer_interrupt_mode_select_in) begin
                            n.rx_of = 1'b1;
                            if (receive_overwrite_enable_in) begin
                                n.rx_buf = link_rx_byte;
                            end
                            // Otherwise the older byte is kept.
                        end else begin
                            stop = 1'b1;
                        end
                    end else begin
                        n.rx_buf  = link_rx_byte;
                        n.rx_irq  = 1'b1;
                        n.rx_full = 1'b1;
                    end
                    // Transmit side: refill the shifter or note underflow.
                    if (tx_avail) begin
                        n.shift_data = tx_next;
                        n.tx_full = 1'b0;
                        n.tx_irq  = 1'b1;
                    end else begin
                        n.tx_uf = 1'b1;
                        n.shift_data = IDLE_FILL;
                        if (transfer_interrupt_mode_select_in
                            || master_mode_in) begin
                            stop = 1'b1;
                        end
                    end
                end
                // A slave frame also ends when the remote master deselects.
                if (!master_mode_in && !slave_sel) begin
                    stop = 1'b1;
                end
                if (stop) begin
                    n.state = IDLE;
                    n.frame = 1'b0;
                    n.ss_n_drive = 1'b1;
                end
            end
        endcase

        n.busy    = (n.state == ACTIVE);
        n.ss_oe_n = ~(master_mode_in && !ss_input_enable_in);
        n.irq     = serial_irq_enable_in && (n.rx_irq || n.tx_irq);

        // Registered read answer; reading status changes nothing.
        if (hit(sfr_addr_in, STATUS_ADDR)) begin
            n.rdata = status_of(r);
        end else if (hit(sfr_addr_in, RX_BUF_ADDR)) begin
            n.rdata = r.rx_buf;
        end else if (hit(sfr_addr_in, TX_BUF_ADDR)) begin
            n.rdata = r.tx_buf;
        end else begin
            n.rdata = BYTE_RESET;
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************

    // All flags start clear; select rests deasserted.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r <= '0;
            r.ss_meta <= 1'b1;
            r.ss_sync <= 1'b1;
            r.ss_n_drive <= 1'b1;
            r.ss_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign sfr_rdata_out  = r.rdata;
    assign serial_irq_out = r.irq;
    assign ss_n_out       = r.ss_n_drive;
    assign ss_oe_n_out    = r.ss_oe_n;

endmodule

`default_nettype wire

// [spi_flag_monitor.sv]
// Purpose: Port-level timing checks on the serial port flag block.
// Assumes: All checks run in the core clock domain.
// Notes:   Bound to the flag block at the foot of this file.

`timescale 1ns/1ps
`default_nettype none

module spi_flag_monitor
    import spi_flag_pkg::*;
(
    // Core clock, reset and register port.
    input wire logic       sys_clk_in,
    input wire logic       reset_n_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic       sfr_wr_in,
    input wire logic       sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    // Configuration, interrupt and select.
    input wire logic       master_mode_in,
    input wire logic       ss_input_enable_in,
    input wire logic       serial_irq_enable_in,
    input wire logic       serial_irq_out,
    input wire logic       ss_n_in,
    input wire logic       ss_n_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    // Idle master with nothing pending; no flag can change by itself here.
    wire logic st_rd = sfr_rd_in && sfr_addr_in == STATUS_ADDR;
    wire logic tx_wr = sfr_wr_in && sfr_addr_in == TX_BUF_ADDR;
    wire logic idle  = master_mode_in && ss_n_out && ss_n_in;

    busy_master_a: assert property (
        st_rd && master_mode_in && !ss_n_out |=> sfr_rdata_out[BUSY_BIT])
        else $error("busy low during a master frame");
    busy_slave_a: assert property (
        (!master_mode_in && !ss_n_in) [*5] ##0 st_rd
        |=> sfr_rdata_out[BUSY_BIT])
        else $error("busy low during a slave frame");
    start_select_a: assert property (
        idle && tx_wr |=> !ss_n_out)
        else $error("select not driven after transmit write");
    hold_idle_a: assert property (
        idle && !tx_wr |=> ss_n_out)
        else $error("select asserted without a transmit byte");
    irq_start_a: assert property (
        idle && serial_irq_enable_in && tx_wr |-> ##[1:3] serial_irq_out)
        else $error("no interrupt after transmit buffer emptied");
    irq_off_a: assert property (
        !serial_irq_enable_in && $past(!serial_irq_enable_in)
        |-> !serial_irq_out)
        else $error("interrupt raised while disabled");
    unmapped_zero_a: assert property (
        sfr_addr_in != STATUS_ADDR && sfr_addr_in != TX_BUF_ADDR &&
        sfr_addr_in != RX_BUF_ADDR |=> sfr_rdata_out == 8'h00)
        else $error("unmapped address read nonzero");
    read_stable_a: assert property (
        idle && st_rd ##2 idle && st_rd |=> $stable(sfr_rdata_out))
        else $error("status read changed the status");
    rx_clear_a: assert property (
        idle && sfr_rd_in && sfr_addr_in == RX_BUF_ADDR ##2 st_rd
        |=> sfr_rdata_out[5:3] == 3'h0)
        else $error("receive flags stay after buffer read");
    flag_clear_a: assert property (
        idle && sfr_wr_in && sfr_addr_in == STATUS_ADDR &&
        sfr_wdata_in == 8'h00 ##2 st_rd
        |=> !sfr_rdata_out[6] && sfr_rdata_out[2:0] == 3'h0)
        else $error("zero write left a writable flag set");
    multimaster_error_flag_set_a: assert property (
        (master_mode_in && ss_input_enable_in && !ss_n_out && !ss_n_in)
        [*5] ##0 st_rd |=> sfr_rdata_out[MULTIMASTER_ERROR_FLAG_BIT])
        else $error("multimaster error not flagged");
endmodule

bind spi_status_flag_logic spi_flag_monitor i_monitor (
    .sys_clk_in, .reset_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in,
    .sfr_wdata_in, .sfr_rdata_out, .master_mode_in, .ss_input_enable_in,
    .serial_irq_enable_in, .serial_irq_out, .ss_n_in, .ss_n_out);

`default_nettype wire

// [spi_remote_model.sv]
// Purpose: Behavioural remote device on the far side of the link.
// Assumes: Link clock of 30 ns, running while a frame is open and for a short tail after it.
// Notes:   Drives one data level per frame so bit alignment cannot matter.

`timescale 1ns/1ps
`default_nettype none

module spi_remote_model (
    // Frame and chosen data level from the bench.
    input  wire logic frame_in,
    input  wire logic level_in,
    // Link pins.
    output logic      link_clk_out,
    output logic      sdi_out
);
    // The clock stands low between frames; odd offset keeps phase unrelated.
    // A short tail of edges after a frame lets the shifter see it close,
    // otherwise its counter would carry a cut byte into the next frame.
    int tail;
    initial begin
        link_clk_out = 1'b0;
        tail = 0;
        #3.7;
        forever begin
            #15;
            if (frame_in) begin
                tail = 8;
            end else if (tail > 0) begin
                tail--;
            end
            link_clk_out = (frame_in || tail > 0) ? ~link_clk_out : 1'b0;
        end
    end

    // A released line shows the inverse so a stale bit is never mistaken.
    initial sdi_out = 1'b0;
    always @(frame_in) sdi_out = frame_in ? level_in : ~sdi_out;
endmodule

`default_nettype wire

// [spi_status_flag_logic_bench.sv]
// Purpose: Self-checking bench of the serial port flag block.
// Assumes: Inputs change on the falling core clock edge.
// Notes:   Reads note an expectation; a watcher compares on arrival.

`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
    compares++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end

module spi_status_flag_logic_bench
    import spi_flag_pkg::*;
;
    // ****************************************************
    // Stimulus, design and remote device.
    // ****************************************************
    int         errors, compares, seed, n;
    logic       clk, rst_n, wr, rd, master, ss_en, mode, ow, irq_en;
    logic       ss_drv, level, seen_rd;
    logic [7:0] addr, wdata, tx, exp_q[$], mask_q[$];
    wire logic [7:0] rdata;
    wire logic       irq, ss_n_out, ss_oe_n, link_clk, sdi, ss_pin, frame;

    // Select pin resolves to whoever enables its drive.
    assign ss_pin = ss_oe_n ? ss_drv : ss_n_out;
    assign frame  = master ? ~ss_n_out : ~ss_pin;

    spi_status_flag_logic i_dut (
        .sys_clk_in(clk), .reset_n_in(rst_n), .sfr_addr_in(addr),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata),
        .sfr_rdata_out(rdata), .master_mode_in(master),
        .ss_input_enable_in(ss_en), .transfer_interrupt_mode_select_in(mode),
        .receive_overwrite_enable_in(ow), .serial_irq_enable_in(irq_en),
        .serial_irq_out(irq), .ss_n_in(ss_pin), .ss_n_out(ss_n_out),
        .ss_oe_n_out(ss_oe_n), .link_clk_in(link_clk),
        .serial_data_in(sdi), .serial_data_out());

    spi_remote_model i_remote (
        .frame_in(frame), .level_in(level),
        .link_clk_out(link_clk), .sdi_out(sdi));

    // Read data lands one cycle after the address, so check a cycle later.
    always @(posedge clk) seen_rd <= rd;
    always @(negedge clk) begin
        if (seen_rd) begin
            `CHK("register read", exp_q[0], rdata & mask_q[0])
            void'(exp_q.pop_front());
            void'(mask_q.pop_front());
        end
    end

    task automatic report_and_stop();
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic sfr_read(input logic [7:0] a, input logic [7:0] e,
                            input logic [7:0] m);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        @(negedge clk);
        rd = 1'b0;
    endtask

    // Bounded wait for the select to rise (0) or the interrupt (1).
    task automatic wait_for(input int which);
        n = 0;
        while ((which == 0 ? ss_n_out : irq) !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n == 3000) begin
            errors++;
            report_and_stop();
        end
        repeat (4) @(negedge clk);
    endtask

    // Starts one or two master bytes and waits until the frame closes.
    task automatic master_run(input int bytes, input logic [7:0] st);
        level = 1'($random(seed));
        tx = 8'($random(seed));
        sfr_write(TX_BUF_ADDR, tx);
        if (bytes == 2) begin
            sfr_write(TX_BUF_ADDR, ~tx);
            sfr_read(STATUS_ADDR, 8'h81, 8'h83);
        end else begin
            sfr_read(STATUS_ADDR, 8'h82, 8'h83);
        end
        wait_for(0);
        sfr_read(STATUS_ADDR, st, 8'hFF);
    endtask

    // ****************************************************
    // Main sequence.
    // ****************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        {errors, compares, seed} = {32'd0, 32'd0, 32'd63906};
        {rst_n, wr, rd, ss_en, ow, ss_drv, level} = 7'h00;
        {master, mode, irq_en, addr, wdata} = {3'h7, 16'h0000};
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        sfr_read(STATUS_ADDR, STATUS_RESET, 8'hFF);
        sfr_read(8'h55, 8'h00, 8'hFF);
        // Single byte, mode 1: stops for lack of a new byte.
        master_run(1, 8'h1E);
        `CHK("interrupt", 1'b1, irq)
        sfr_read(STATUS_ADDR, 8'h1E, 8'hFF);
        sfr_read(RX_BUF_ADDR, {8{level}}, 8'hFF);
        sfr_read(STATUS_ADDR, 8'h06, 8'hFF);
        sfr_write(STATUS_ADDR, 8'hFB);
        sfr_read(STATUS_ADDR, 8'h02, 8'hFF);
        sfr_write(STATUS_ADDR, 8'h00);
        sfr_read(STATUS_ADDR, 8'h00, 8'hFF);
        `CHK("interrupt", 1'b0, irq)
        // Two bytes with the first left unread gives an overflow.
        ow = 1'($random(seed));
        master_run(2, 8'h3E);
        sfr_read(RX_BUF_ADDR, {8{level}}, 8'hFF);
        sfr_read(STATUS_ADDR, 8'h06, 8'hFF);
        sfr_write(STATUS_ADDR, 8'h00);
        // Mode 0 stops instead of flagging an overflow.
        mode = 1'b0;
        master_run(2, 8'h1E);
        sfr_read(RX_BUF_ADDR, {8{level}}, 8'hFF);
        sfr_write(STATUS_ADDR, 8'h00);
        // Another master pulls select low during our frame.
        ss_en = 1'b1;
        ss_drv = 1'b1;
        sfr_write(TX_BUF_ADDR, 8'h5A);
        ss_drv = 1'b0;
        repeat (6) @(negedge clk);
        sfr_read(STATUS_ADDR, 8'h40, 8'h40);
        ss_drv = 1'b1;
        wait_for(0);
        sfr_write(STATUS_ADDR, 8'hBF);
        sfr_read(STATUS_ADDR, 8'h00, 8'h40);
        sfr_read(RX_BUF_ADDR, 8'h00, 8'h00);
        sfr_write(STATUS_ADDR, 8'h00);
        // Slave role: a remote master selects us and sends one byte.
        master = 1'b0;
        level = 1'($random(seed));
        ss_drv = 1'b0;
        repeat (6) @(negedge clk);
        sfr_read(STATUS_ADDR, 8'h80, 8'h80);
        wait_for(1);
        ss_drv = 1'b1;
        repeat (8) @(negedge clk);
        sfr_read(STATUS_ADDR, 8'h18, 8'h98);
        sfr_read(RX_BUF_ADDR, {8{level}}, 8'hFF);
        repeat (4) @(negedge clk);
        report_and_stop();
    end
endmodule

`default_nettype wire
